// ==== logic/pcx_regs.svh ====
// Purpose: Register offsets, field positions and reset values of the pin-change block.
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register, data in bits 7:0.
// Notes: Included by the package and by the top module.
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

`define PCX_ADDR_W 8
`define PCX_OFS_FLAGS 8'h00
`define PCX_OFS_ENABLE 8'h04
`define PCX_OFS_SENSE 8'h08
`define PCX_OFS_UPPER_MASK 8'h0C
`define PCX_OFS_LOWER_MASK 8'h10
`define PCX_OFS_CPU_STATUS 8'h14

`define PCX_BIT_UPPER 7
`define PCX_BIT_LOWER 6
`define PCX_BIT_EXT 0
`define PCX_BIT_GIE 7

`define PCX_RST_BYTE 8'h00
`define PCX_RST_SENSE 2'h0

`define PCX_RESP_OKAY 2'h0
`define PCX_RESP_SLVERR 2'h2

`define PCX_ACK_EXT 0
`define PCX_ACK_LOWER 1
`define PCX_ACK_UPPER 2

`endif

// ==== logic/pcx_pkg.sv ====
// Purpose: Types shared by the pin-change interrupt block.
// Assumes: Constants come from pcx_regs.svh.
// Notes: The sense enum follows the two sense-control bits.
`include "pcx_regs.svh"
package pcx_pkg;
    typedef enum logic [1:0] {
        PCX_SENSE_LOW = 2'h0,
        PCX_SENSE_ANY = 2'h1,
        PCX_SENSE_FALL = 2'h2,
        PCX_SENSE_RISE = 2'h3
    } pcx_sense_t;
endpackage : pcx_pkg

// ==== logic/pcx_sync.sv ====
// Purpose: Two-stage synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to sys_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pcx_sync #(
    parameter int WIDTH = 17
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Pin levels in and synchronised levels out.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage_one;

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    stage_one[i] <= 1'b1;
                    pin_sync[i] <= 1'b1;
                end else begin
                    stage_one[i] <= pin_in[i];
                    pin_sync[i] <= stage_one[i];
                end
            end
        end
    endgenerate
endmodule : pcx_sync
`default_nettype wire

// ==== logic/pcx_irq_top.sv ====
// Purpose: External and pin-change interrupt flags, masks and dispatch requests.
// Assumes: AXI4-Lite register access; vector acknowledges come from the CPU on sys_clk.
// Notes: Every output is registered.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pcx_regs.svh"
module pcx_irq_top
    import pcx_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write address and data.
    input wire logic [`PCX_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [`PCX_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and I/O clock state.
    input wire logic ext_irq_pin,
    input wire logic [7:0] upper_change_pins,
    input wire logic [7:0] lower_change_pins,
    input wire logic io_clk_en,
    // CPU dispatch.
    input wire logic [2:0] vector_ack,
    output logic irq_ext_req,
    output logic irq_lower_req,
    output logic irq_upper_req,
    output logic irq
);
    logic [7:0] ext_irq_enable_reg;
    logic [7:0] upper_pin_change_mask;
    logic [7:0] lower_pin_change_mask;
    logic [7:0] cpu_status_reg;
    pcx_sense_t sense_ctrl;
    logic upper_group_flag, lower_group_flag, ext_pin_flag;
    logic [16:0] pins_raw, pins_now, pins_prev;
    logic [7:0] upper_change, lower_change;
    logic ext_now, ext_prev;
    logic upper_set, lower_set, ext_set;
    logic upper_clr, lower_clr, ext_clr;
    logic upper_group_enable, lower_group_enable, ext_enable, global_enable;
    logic next_irq_ext_req, next_irq_lower_req, next_irq_upper_req;
    logic [`PCX_ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q;
    logic aw_have, w_have, do_write, wr_byte;
    logic [7:0] rd_value;
    logic rd_hit, wr_hit;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and previous samples.
    assign pins_raw = {ext_irq_pin, upper_change_pins, lower_change_pins};

    pcx_sync #(
        .WIDTH(17)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pin_in(pins_raw),
        .pin_sync(pins_now)
    );

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pins_prev <= 17'h1FFFF;
        end else begin
            pins_prev <= pins_now;
        end
    end

    assign ext_now = pins_now[16];
    assign ext_prev = pins_prev[16];
    assign upper_group_enable = ext_irq_enable_reg[`PCX_BIT_UPPER];
    assign lower_group_enable = ext_irq_enable_reg[`PCX_BIT_LOWER];
    assign ext_enable = ext_irq_enable_reg[`PCX_BIT_EXT];
    assign global_enable = cpu_status_reg[`PCX_BIT_GIE];

    ////////////////////////////////////////////////////////////////////////
    // Change and edge detection.
    // pad levels used whatever the pin direction.
    // pin changes need no I/O clock.
    assign upper_change = pins_now[15:8] ^ pins_prev[15:8];
    assign lower_change = pins_now[7:0] ^ pins_prev[7:0];

    assign upper_set = upper_group_enable && ((upper_change & upper_pin_change_mask) != 8'h00);
    assign lower_set = lower_group_enable && ((lower_change & lower_pin_change_mask) != 8'h00);

    always_comb begin
        ext_set = 1'b0;
        unique case (sense_ctrl)
            PCX_SENSE_LOW: ext_set = 1'b0;
            PCX_SENSE_ANY: ext_set = io_clk_en && (ext_now != ext_prev);
            PCX_SENSE_FALL: ext_set = io_clk_en && ext_prev && !ext_now;
            PCX_SENSE_RISE: ext_set = io_clk_en && !ext_prev && ext_now;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags.
    assign wr_byte = do_write && w_strb_q;
    // clear by write-one or handler entry.
    assign upper_clr = vector_ack[`PCX_ACK_UPPER] ||
        (wr_byte && aw_addr_q == `PCX_OFS_FLAGS && w_data_q[`PCX_BIT_UPPER]);
    assign lower_clr = vector_ack[`PCX_ACK_LOWER] ||
        (wr_byte && aw_addr_q == `PCX_OFS_FLAGS && w_data_q[`PCX_BIT_LOWER]);
    assign ext_clr = vector_ack[`PCX_ACK_EXT] ||
        (wr_byte && aw_addr_q == `PCX_OFS_FLAGS && w_data_q[`PCX_BIT_EXT]);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            upper_group_flag <= 1'b0;
        end else begin
            upper_group_flag <= (upper_group_flag && !upper_clr) || upper_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lower_group_flag <= 1'b0;
        end else begin
            lower_group_flag <= (lower_group_flag && !lower_clr) || lower_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_pin_flag <= 1'b0;
        end else if (sense_ctrl == PCX_SENSE_LOW) begin
            ext_pin_flag <= 1'b0;
        end else begin
            ext_pin_flag <= (ext_pin_flag && !ext_clr) || ext_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dispatch requests.
    // upper dispatch gating.
    assign next_irq_upper_req = upper_group_flag && upper_group_enable && global_enable;
    assign next_irq_lower_req = lower_group_flag && lower_group_enable && global_enable;
    assign next_irq_ext_req = ext_enable && global_enable &&
        ((sense_ctrl == PCX_SENSE_LOW) ? !ext_now : ext_pin_flag);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_upper_req <= 1'b0;
            irq_lower_req <= 1'b0;
            irq_ext_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_upper_req <= next_irq_upper_req;
            irq_lower_req <= next_irq_lower_req;
            irq_ext_req <= next_irq_ext_req;
            irq <= next_irq_upper_req || next_irq_lower_req || next_irq_ext_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.
    assign do_write = aw_have && w_have && !s_axi_bvalid;
    assign wr_hit = aw_addr_q == `PCX_OFS_FLAGS || aw_addr_q == `PCX_OFS_ENABLE ||
        aw_addr_q == `PCX_OFS_SENSE || aw_addr_q == `PCX_OFS_UPPER_MASK ||
        aw_addr_q == `PCX_OFS_LOWER_MASK || aw_addr_q == `PCX_OFS_CPU_STATUS;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            aw_have <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else begin
            if (do_write) begin
                aw_have <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_axi_wready <= 1'b1;
            w_have <= 1'b0;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_strb_q <= s_axi_wstrb[0];
        end else begin
            if (do_write) begin
                w_have <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PCX_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PCX_RESP_OKAY : `PCX_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers written by software.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ext_irq_enable_reg <= `PCX_RST_BYTE;
            upper_pin_change_mask <= `PCX_RST_BYTE;
            lower_pin_change_mask <= `PCX_RST_BYTE;
            cpu_status_reg <= `PCX_RST_BYTE;
            sense_ctrl <= PCX_SENSE_LOW;
        end else if (wr_byte) begin
            unique case (aw_addr_q)
                `PCX_OFS_ENABLE: ext_irq_enable_reg <= w_data_q & 8'hC1;
                `PCX_OFS_SENSE: sense_ctrl <= pcx_sense_t'(w_data_q[1:0]);
                `PCX_OFS_UPPER_MASK: upper_pin_change_mask <= w_data_q;
                `PCX_OFS_LOWER_MASK: lower_pin_change_mask <= w_data_q;
                `PCX_OFS_CPU_STATUS: cpu_status_reg <= w_data_q & 8'h80;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.
    always_comb begin
        rd_value = 8'h00;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `PCX_OFS_FLAGS: rd_value = {upper_group_flag, lower_group_flag, 5'h00, ext_pin_flag};
            `PCX_OFS_ENABLE: rd_value = ext_irq_enable_reg;
            `PCX_OFS_SENSE: rd_value = {6'h00, sense_ctrl};
            `PCX_OFS_UPPER_MASK: rd_value = upper_pin_change_mask;
            `PCX_OFS_LOWER_MASK: rd_value = lower_pin_change_mask;
            `PCX_OFS_CPU_STATUS: rd_value = cpu_status_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PCX_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_value};
            s_axi_rresp <= rd_hit ? `PCX_RESP_OKAY : `PCX_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_upper_flag_set: assert property (upper_set |=> upper_group_flag)
        else $error("Upper group flag missed a change.");
    a_lower_flag_set: assert property (lower_set |=> lower_group_flag)
        else $error("Lower group flag missed a change.");
    a_ext_rise_set: assert property ((sense_ctrl == PCX_SENSE_RISE && io_clk_en && !ext_prev && ext_now)
        |=> ext_pin_flag)
        else $error("External flag missed a rising edge.");
    a_upper_dispatch_gate: assert property (irq_upper_req
        |-> $past(upper_group_flag && upper_group_enable && global_enable))
        else $error("Upper dispatch without its conditions.");
    a_lower_dispatch_gate: assert property (irq_lower_req
        |-> $past(lower_group_flag && lower_group_enable && global_enable))
        else $error("Lower dispatch without its conditions.");
    a_ext_dispatch_gate: assert property ((sense_ctrl != PCX_SENSE_LOW && ext_pin_flag && ext_enable
        && global_enable) ##1 (sense_ctrl != PCX_SENSE_LOW) |-> irq_ext_req)
        else $error("External dispatch missing.");
    a_ack_clears_flag: assert property ((vector_ack[`PCX_ACK_UPPER] && !upper_set)
        |=> !upper_group_flag)
        else $error("Upper flag not cleared on handler entry.");
    a_level_flag_clear: assert property ((sense_ctrl == PCX_SENSE_LOW) |=> !ext_pin_flag)
        else $error("External flag set in level mode.");
    a_upper_mask_off: assert property ((upper_pin_change_mask == 8'h00) |=> !$rose(upper_group_flag))
        else $error("Upper flag rose with all pins masked.");
    a_level_request: assert property ((sense_ctrl == PCX_SENSE_LOW && ext_enable && global_enable
        && !ext_now) [*2] |=> irq_ext_req)
        else $error("Low level request not held.");
    a_set_beats_clear: assert property ((lower_clr && lower_set) |=> lower_group_flag)
        else $error("Lower set lost against a clear.");
    a_write_response: assert property (do_write |=> s_axi_bvalid)
        else $error("Write response late.");

    c_upper_dispatch: cover property (upper_set ##1 upper_group_flag ##1 irq_upper_req);
    c_ext_falling: cover property (sense_ctrl == PCX_SENSE_FALL && ext_set ##1 ext_pin_flag);
    c_level_req: cover property (sense_ctrl == PCX_SENSE_LOW ##1 irq_ext_req);
    c_read_done: cover property (s_axi_rvalid && s_axi_rready);
endmodule : pcx_irq_top
`default_nettype wire

// ==== verif/pcx_dispatch_model.sv ====
// Purpose: Processor dispatch partner that enters handlers for the block's requests.
// Assumes: Requests are levels on sys_clk; an acknowledge is a one-cycle pulse.
// Notes: The answer delay is set by the bench, and a hold-off lets a request drop after its acknowledge.
`timescale 1ns/1ps
`default_nettype none
module pcx_dispatch_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset_n,
    // Requests from the block.
    input wire logic irq_ext_req,
    input wire logic irq_lower_req,
    input wire logic irq_upper_req,
    // Bench control.
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    // Handler entry and count of handlers entered.
    output logic [2:0] vector_ack,
    output logic [7:0] ack_count
);
    logic [3:0] wait_cnt;
    logic [2:0] hold;

    ////////////////////////////////////////////////////////////////////////////////
    // Enters one handler at a time, external first, then lower, then upper.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            vector_ack <= 3'h0;
            ack_count <= 8'h00;
            wait_cnt <= 4'h0;
            hold <= 3'h0;
        end else begin
            vector_ack <= 3'h0;
            if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end else if (ack_en && (irq_ext_req || irq_lower_req || irq_upper_req)) begin
                if (wait_cnt < ack_delay) begin
                    wait_cnt <= wait_cnt + 4'h1;
                end else begin
                    vector_ack <= irq_ext_req ? 3'h1 : (irq_lower_req ? 3'h2 : 3'h4);
                    ack_count <= ack_count + 8'h01;
                    wait_cnt <= 4'h0;
                    hold <= 3'h4;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule : pcx_dispatch_model
`default_nettype wire

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the pin-change and external interrupt block.
// Assumes: AXI4-Lite master tasks here; dispatch by the partner model.
// Notes: Expected flags and requests come from a small model kept in the bench.
`timescale 1ns/1ps
`default_nettype none
`include "pcx_regs.svh"
module tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic ext_irq_pin = 1'b1;
    logic [7:0] upper_change_pins = 8'hFF;
    logic [7:0] lower_change_pins = 8'hFF;
    logic io_clk_en = 1'b1;
    logic ack_en = 1'b0;
    logic [3:0] ack_delay = 4'h0;
    logic [2:0] vector_ack;
    logic [7:0] ack_count;
    logic irq_ext_req, irq_lower_req, irq_upper_req, irq;
    logic [7:0] m_flags = 8'h00;
    logic [7:0] m_en = 8'h00;
    logic m_gie = 1'b0;
    logic [1:0] m_sense = 2'h0;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    pcx_irq_top pcx_irq_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_irq_pin(ext_irq_pin),
        .upper_change_pins(upper_change_pins), .lower_change_pins(lower_change_pins),
        .io_clk_en(io_clk_en), .vector_ack(vector_ack), .irq_ext_req(irq_ext_req),
        .irq_lower_req(irq_lower_req), .irq_upper_req(irq_upper_req), .irq(irq));

    pcx_dispatch_model pcx_dispatch_model_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .irq_ext_req(irq_ext_req), .irq_lower_req(irq_lower_req), .irq_upper_req(irq_upper_req),
        .ack_en(ack_en), .ack_delay(ack_delay), .vector_ack(vector_ack), .ack_count(ack_count));

    always #25 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : ticks

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = `PCX_RESP_OKAY);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        check({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `PCX_RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        while (s_axi_arready !== 1'b1) @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        @(posedge sys_clk);
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd

    task automatic req_chk();
        logic [2:0] e;
        e[2] = m_flags[7] & m_en[7] & m_gie;
        e[1] = m_flags[6] & m_en[6] & m_gie;
        e[0] = m_en[0] & m_gie & ((m_sense == 2'h0) ? ~ext_irq_pin : m_flags[0]);
        ticks(3);
        check({28'h0, irq, irq_upper_req, irq_lower_req, irq_ext_req}, {28'h0, |e, e});
    endtask : req_chk

    task automatic toggle(input int g, input int k);
        if (g != 0) begin
            upper_change_pins <= upper_change_pins ^ (8'h01 << k);
        end else begin
            lower_change_pins <= lower_change_pins ^ (8'h01 << k);
        end
    endtask : toggle

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int g;
        int k;
        int c;
        logic [7:0] v;
        logic [7:0] n;
        void'($urandom(69));
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (k = 0; k < 6; k++) rd(8'(k * 4), 32'h0);
        rd(8'h18, 32'h0, `PCX_RESP_SLVERR);
        wr(8'h18, 8'hFF, `PCX_RESP_SLVERR);
        req_chk();
        $display("Test reset and decode done");
        v = 8'($urandom);
        n = 8'($urandom);
        wr(`PCX_OFS_UPPER_MASK, v);
        rd(`PCX_OFS_UPPER_MASK, {24'h0, v});
        wr(`PCX_OFS_LOWER_MASK, n);
        rd(`PCX_OFS_LOWER_MASK, {24'h0, n});
        wr(`PCX_OFS_ENABLE, 8'hFF);
        rd(`PCX_OFS_ENABLE, 32'hC1);
        wr(`PCX_OFS_SENSE, 8'hFF);
        rd(`PCX_OFS_SENSE, 32'h3);
        wr(`PCX_OFS_CPU_STATUS, 8'hFF);
        rd(`PCX_OFS_CPU_STATUS, 32'h80);
        for (k = 0; k < 6; k++) wr(8'(k * 4), 8'h00);
        s_axi_wstrb <= 4'hE;
        wr(`PCX_OFS_ENABLE, 8'hFF);
        s_axi_wstrb <= 4'hF;
        rd(`PCX_OFS_ENABLE, 32'h0);
        $display("Test register access done");
        for (g = 0; g < 2; g++) begin
            k = $urandom % 8;
            io_clk_en <= 1'b0;
            m_gie = 1'b0;
            wr(`PCX_OFS_CPU_STATUS, 8'h00);
            wr(g ? `PCX_OFS_UPPER_MASK : `PCX_OFS_LOWER_MASK, 8'h01 << k);
            toggle(g, k);
            ticks(6);
            rd(`PCX_OFS_FLAGS, 32'h0);
            m_en = g ? 8'h80 : 8'h40;
            wr(`PCX_OFS_ENABLE, m_en);
            toggle(g, (k + 1) % 8);
            ticks(6);
            rd(`PCX_OFS_FLAGS, 32'h0);
            toggle(g, k);
            ticks(6);
            m_flags = m_en;
            rd(`PCX_OFS_FLAGS, {24'h0, m_flags});
            req_chk();
            m_gie = 1'b1;
            wr(`PCX_OFS_CPU_STATUS, 8'h80);
            req_chk();
            wr(`PCX_OFS_FLAGS, ~m_flags);
            rd(`PCX_OFS_FLAGS, {24'h0, m_flags});
            wr(`PCX_OFS_FLAGS, m_flags);
            m_flags = 8'h00;
            rd(`PCX_OFS_FLAGS, 32'h0);
            req_chk();
            n = ack_count;
            ack_delay <= 4'($urandom % 6);
            ack_en <= 1'b1;
            toggle(g, k);
            ticks(16);
            rd(`PCX_OFS_FLAGS, 32'h0);
            check({24'h0, ack_count}, {24'h0, n + 8'h01});
            ack_en <= 1'b0;
            m_en = 8'h00;
            wr(`PCX_OFS_ENABLE, 8'h00);
            $display("Test pin-change group %0d done", g);
        end
        io_clk_en <= 1'b1;
        m_en = 8'h01;
        wr(`PCX_OFS_ENABLE, 8'h01);
        for (c = 1; c < 4; c++) begin
            m_sense = 2'(c);
            wr(`PCX_OFS_SENSE, 8'(c));
            ext_irq_pin <= 1'b0;
            ticks(6);
            m_flags[0] = (c != 3);
            rd(`PCX_OFS_FLAGS, {24'h0, m_flags});
            req_chk();
            wr(`PCX_OFS_FLAGS, 8'h01);
            m_flags = 8'h00;
            ext_irq_pin <= 1'b1;
            ticks(6);
            m_flags[0] = (c != 2);
            rd(`PCX_OFS_FLAGS, {24'h0, m_flags});
            req_chk();
            wr(`PCX_OFS_FLAGS, 8'h01);
            m_flags = 8'h00;
        end
        io_clk_en <= 1'b0;
        m_sense = 2'h1;
        wr(`PCX_OFS_SENSE, 8'h01);
        ext_irq_pin <= 1'b0;
        ticks(6);
        rd(`PCX_OFS_FLAGS, 32'h0);
        ext_irq_pin <= 1'b1;
        ticks(6);
        rd(`PCX_OFS_FLAGS, 32'h0);
        io_clk_en <= 1'b1;
        $display("Test external edge modes done");
        m_sense = 2'h0;
        wr(`PCX_OFS_SENSE, 8'h00);
        ext_irq_pin <= 1'b0;
        ticks(6);
        rd(`PCX_OFS_FLAGS, 32'h0);
        req_chk();
        ticks(20);
        req_chk();
        ext_irq_pin <= 1'b1;
        ticks(6);
        req_chk();
        rd(`PCX_OFS_FLAGS, 32'h0);
        $display("Test external level mode done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
